// ===== hdl/rtc_alarm_pkg.sv
// Constants and carrier types for the alarm, timer and frequency-output block
package rtc_alarm_pkg;
	localparam logic [3:0] ADDR_ALARM_MINUTE = 4'h7;
	localparam logic [3:0] ADDR_ALARM_HOUR = 4'h8;
	localparam logic [3:0] ADDR_ALARM_WEEKDAY = 4'h9;
	localparam logic [3:0] ADDR_ALARM_DAY = 4'hA;
	localparam logic [3:0] ADDR_FREQ_OUTPUT = 4'hB;
	localparam logic [3:0] ADDR_TIMER_SOURCE = 4'hC;
	localparam logic [3:0] ADDR_INTERVAL = 4'hD;
	localparam logic [3:0] ADDR_IRQ_CTRL = 4'hE;
	localparam logic [3:0] ADDR_CLOCK_CTRL = 4'hF;
	// Field positions
	localparam int ALARM_MASK_BIT = 7;
	localparam int FREQ_ENABLE_BIT = 7;
	localparam int FREQ_SRC_SEL1_BIT = 4;
	localparam int FREQ_SRC_SEL0_BIT = 3;
	localparam int FREQ_DIV_LSB = 0;
	localparam int RUN_BIT = 7;
	localparam int TIMER_SRC_SEL1_BIT = 5;
	localparam int TIMER_SRC_SEL0_BIT = 4;
	localparam int TIMER_IRQ_EN_BIT = 0;
	localparam int ALARM_IRQ_EN_BIT = 1;
	localparam int TIMER_FLAG_BIT = 2;
	localparam int ALARM_FLAG_BIT = 3;
	localparam int PULSE_MODE_BIT = 4;
	localparam int HOLD_BIT = 3;
	localparam int CNT_RESET_BIT = 4;
	// Registers power up undefined; zero is the chosen reset value
	localparam logic [7:0] REG_RESET = 8'h00;
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int RTN_SHORT_NS = 122_000;
	localparam int RTN_MID_NS = 7_810_000;
	localparam int RTN_LONG_NS = 500_000_000;
	localparam int RTN_SHORT_CYC = RTN_SHORT_NS / CLK_PERIOD_NS;
	localparam int RTN_MID_CYC = RTN_MID_NS / CLK_PERIOD_NS;
	localparam int RTN_LONG_CYC = RTN_LONG_NS / CLK_PERIOD_NS;
	localparam int RTN_W = 24;
	localparam int DIV_W = 16;
	localparam logic [5:0] SECONDS_LAST = 6'h3B;

	typedef struct packed {
		logic [7:0] minute;
		logic [7:0] hour;
		logic [7:0] weekday;
		logic [7:0] day;
	} cal_time_t;

	typedef struct packed {
		logic en;
		logic [3:0] addr;
		logic [7:0] data;
	} reg_wr_t;

	// Divider ratio for the three low frequency select bits
	function automatic logic [4:0] freq_ratio(input logic [2:0] sel);
		logic [4:0] r;
		r = 5'h01;
		unique case (sel)
			3'h0: r = 5'h01;
			3'h1: r = 5'h02;
			3'h2: r = 5'h03;
			3'h3: r = 5'h06;
			3'h4: r = 5'h05;
			3'h5: r = 5'h0A;
			3'h6: r = 5'h0F;
			3'h7: r = 5'h1E;
		endcase
		return r;
	endfunction
endpackage

// ===== hdl/rtc_alarm_timer.sv
// Alarm compare, interval timer, frequency output and control bits
// Notes on behaviour
// - Weekday bits 0..6 are Sunday..Saturday, multi-select.
// - Alarm bit 7 clear means compare field.
// - Alarm bit 7 set means field always matches.
// - Timer source codes 0, 2, 1, 3 pick 4096, 64, 1 Hz, minute.
// - Count reaching zero raises event, reloads, continues.
// - Writing interval register loads preset and count.
// - Interval register keeps written value as storage.
// - Run bit clear holds preset in counter.
// - Frequency source picks 32768, 1024, 32, 1 Hz.
// - Low frequency bits divide by 1,2,3,6,5,10,15,30.
// - Frequency enable clear keeps pin released.
// - Level mode holds pin low until flag cleared.
// - Repetitive mode releases pin after return time.
// - Flags set by events, cleared only by zero.
// - Counter reset clears dividers; chip-enable low clears it.
// - Hold stops seconds, one missed step applied later.
// - Return times 0.122, 7.81, 500, 0.122 ms.
// - Alarm checked when seconds carry into minutes.
`timescale 1ns/100ps
module rtc_alarm_timer
	import rtc_alarm_pkg::*;
#(
	parameter int unsigned RTN_MID_CYCLES = RTN_MID_CYC,
	parameter int unsigned RTN_LONG_CYCLES = RTN_LONG_CYC
)
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic osc_in,
	input wire reg_wr_t reg_wr,
	input wire logic [3:0] rd_addr,
	input wire logic ce_fall,
	input wire cal_time_t cal,
	input wire logic sec_carry,
	output logic [7:0] rd_data,
	output logic sec_inc,
	output logic clock_func_reset,
	output logic irq_out_n,
	output logic irq_out_n_oe
);

	logic osc_s1_q, osc_s2_q, osc_s3_q;
	logic osc_edge;
	logic [DIV_W-1:0] div_q;
	logic [5:0] sec_cnt_q;
	logic tick_4096, tick_64, tick_1hz, tick_min;
	logic [7:0] alarm_q [0:3];
	logic [1:0] alarm_idx;
	logic [7:0] freq_sel_q, timer_sel_q, preset_q, count_q;
	logic [7:0] ctrl1_q, ctrl2_q;
	logic af_q, tf_q;
	logic wr_e, wr_f;
	logic [1:0] tsel, fsel;
	logic timer_tick, timer_event;
	logic [3:0] field_match;
	logic alarm_event;
	logic [RTN_W-1:0] rtn_len, rtn_cnt_q;
	logic fhalf;
	logic [4:0] fcnt_q, ratio;
	logic wave_q;
	logic pend_q;
	logic timer_irq_enable, alarm_irq_enable, pulse_mode, fe, hold, cnt_reset;
	logic drive_low;

	assign timer_irq_enable = ctrl1_q[TIMER_IRQ_EN_BIT];
	assign alarm_irq_enable = ctrl1_q[ALARM_IRQ_EN_BIT];
	assign pulse_mode = ctrl1_q[PULSE_MODE_BIT];
	assign fe = freq_sel_q[FREQ_ENABLE_BIT];
	assign hold = ctrl2_q[HOLD_BIT];
	assign cnt_reset = ctrl2_q[CNT_RESET_BIT];
	assign wr_e = reg_wr.en && reg_wr.addr == ADDR_IRQ_CTRL;
	assign wr_f = reg_wr.en && reg_wr.addr == ADDR_CLOCK_CTRL;

	////////////////////////////////////////////////////////////////////////
	// Oscillator sampling and divider chain

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
		end
		else
		begin
			osc_s1_q <= osc_in;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end

	// Both oscillator edges count, so the divider runs at 65536 Hz
	assign osc_edge = osc_s2_q ^ osc_s3_q;

	always_ff @(posedge mclk)
	begin
		if (reset || cnt_reset)
			div_q <= '0;
		else if (osc_edge)
			div_q <= div_q + 1'b1;
	end

	assign tick_4096 = osc_edge && (&div_q[3:0]);
	assign tick_64 = osc_edge && (&div_q[9:0]);
	assign tick_1hz = osc_edge && (&div_q);
	assign tick_min = tick_1hz && sec_cnt_q == SECONDS_LAST;

	always_ff @(posedge mclk)
	begin
		if (reset || cnt_reset)
			sec_cnt_q <= '0;
		else if (tick_min)
			sec_cnt_q <= '0;
		else if (tick_1hz)
			sec_cnt_q <= sec_cnt_q + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Register file

	assign alarm_idx = 2'(reg_wr.addr - ADDR_ALARM_MINUTE);

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			for (int i = 0; i < 4; i++)
				alarm_q[i] <= REG_RESET;
			freq_sel_q <= REG_RESET;
			timer_sel_q <= REG_RESET;
			preset_q <= REG_RESET;
			ctrl1_q <= REG_RESET;
		end
		else if (reg_wr.en)
		begin
			if (reg_wr.addr >= ADDR_ALARM_MINUTE
				&& reg_wr.addr <= ADDR_ALARM_DAY)
				alarm_q[alarm_idx] <= reg_wr.data;
			if (reg_wr.addr == ADDR_FREQ_OUTPUT)
				freq_sel_q <= reg_wr.data;
			if (reg_wr.addr == ADDR_TIMER_SOURCE)
				timer_sel_q <= reg_wr.data;
			if (reg_wr.addr == ADDR_INTERVAL)
				preset_q <= reg_wr.data;
			if (wr_e)
				ctrl1_q <= reg_wr.data;
		end
	end

	// Counter reset bit also drops when chip enable falls
	always_ff @(posedge mclk)
	begin
		if (reset)
			ctrl2_q <= REG_RESET;
		else if (wr_f)
			ctrl2_q <= reg_wr.data;
		else if (ce_fall)
			ctrl2_q[CNT_RESET_BIT] <= 1'b0;
	end

	// Interval register reads back the preset, not the live count
	always_ff @(posedge mclk)
	begin
		if (reset)
			rd_data <= '0;
		else
		begin
			unique case (rd_addr)
				ADDR_ALARM_MINUTE: rd_data <= alarm_q[0];
				ADDR_ALARM_HOUR: rd_data <= alarm_q[1];
				ADDR_ALARM_WEEKDAY: rd_data <= alarm_q[2];
				ADDR_ALARM_DAY: rd_data <= alarm_q[3];
				ADDR_FREQ_OUTPUT: rd_data <= freq_sel_q;
				ADDR_TIMER_SOURCE: rd_data <= timer_sel_q;
				ADDR_INTERVAL: rd_data <= preset_q;
				ADDR_IRQ_CTRL:
				begin
					rd_data <= ctrl1_q;
					rd_data[ALARM_FLAG_BIT] <= af_q;
					rd_data[TIMER_FLAG_BIT] <= tf_q;
				end
				ADDR_CLOCK_CTRL: rd_data <= ctrl2_q;
				default: rd_data <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Alarm compare

	// Masked fields always match; weekday matches on any common day bit
	assign field_match[0] = alarm_q[0][ALARM_MASK_BIT]
		|| alarm_q[0][6:0] == cal.minute[6:0];
	assign field_match[1] = alarm_q[1][ALARM_MASK_BIT]
		|| alarm_q[1][5:0] == cal.hour[5:0];
	assign field_match[2] = alarm_q[2][ALARM_MASK_BIT]
		|| (|(alarm_q[2][6:0] & cal.weekday[6:0]));
	assign field_match[3] = alarm_q[3][ALARM_MASK_BIT]
		|| alarm_q[3][5:0] == cal.day[5:0];
	assign alarm_event = sec_carry && (&field_match);

	////////////////////////////////////////////////////////////////////////
	// Interval timer

	assign tsel = {timer_sel_q[TIMER_SRC_SEL0_BIT],
		timer_sel_q[TIMER_SRC_SEL1_BIT]};

	always_comb
	begin
		timer_tick = 1'b0;
		rtn_len = RTN_W'(RTN_SHORT_CYC);
		unique case (tsel)
			2'h0: timer_tick = tick_4096;
			2'h1:
			begin
				timer_tick = tick_64;
				rtn_len = RTN_W'(RTN_MID_CYCLES);
			end
			2'h2:
			begin
				timer_tick = tick_1hz;
				rtn_len = RTN_W'(RTN_LONG_CYCLES);
			end
			2'h3: timer_tick = tick_min;
		endcase
	end

	assign timer_event = timer_sel_q[RUN_BIT] && timer_tick
		&& count_q <= 8'h01 && !(reg_wr.en && reg_wr.addr == ADDR_INTERVAL);

	always_ff @(posedge mclk)
	begin
		if (reset)
			count_q <= REG_RESET;
		else if (reg_wr.en && reg_wr.addr == ADDR_INTERVAL)
			count_q <= reg_wr.data;
		else if (!timer_sel_q[RUN_BIT])
			count_q <= preset_q;
		else if (timer_event)
			count_q <= preset_q;
		else if (timer_tick)
			count_q <= count_q - 1'b1;
	end

	// Set wins over a clear in the same cycle; writing one does nothing
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			af_q <= 1'b0;
			tf_q <= 1'b0;
		end
		else
		begin
			if (alarm_event)
				af_q <= 1'b1;
			else if (wr_e && !reg_wr.data[ALARM_FLAG_BIT])
				af_q <= 1'b0;
			if (timer_event)
				tf_q <= 1'b1;
			else if (wr_e && !reg_wr.data[TIMER_FLAG_BIT])
				tf_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			rtn_cnt_q <= '0;
		else if (timer_event && pulse_mode)
			rtn_cnt_q <= rtn_len;
		else if (rtn_cnt_q != '0)
			rtn_cnt_q <= rtn_cnt_q - 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Frequency output

	assign fsel = {freq_sel_q[FREQ_SRC_SEL1_BIT],
		freq_sel_q[FREQ_SRC_SEL0_BIT]};
	assign ratio = freq_ratio(freq_sel_q[FREQ_DIV_LSB+2:FREQ_DIV_LSB]);

	// Half-period ticks of the chosen source
	always_comb
	begin
		fhalf = 1'b0;
		unique case (fsel)
			2'h0: fhalf = osc_edge;
			2'h1: fhalf = osc_edge && (&div_q[4:0]);
			2'h2: fhalf = osc_edge && (&div_q[9:0]);
			2'h3: fhalf = osc_edge && (&div_q[14:0]);
		endcase
	end

	// Odd ratios still give an even duty; each output half spans ratio source half-periods
	always_ff @(posedge mclk)
	begin
		if (reset || cnt_reset)
		begin
			fcnt_q <= '0;
			wave_q <= 1'b1;
		end
		else if (fhalf)
		begin
			if (fcnt_q >= ratio - 5'h01)
			begin
				fcnt_q <= '0;
				wave_q <= !wave_q;
			end
			else
				fcnt_q <= fcnt_q + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Hold of the seconds step

	always_ff @(posedge mclk)
	begin
		if (reset)
			pend_q <= 1'b0;
		else if (hold && tick_1hz)
			pend_q <= 1'b1;
		else if (!hold)
			pend_q <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			sec_inc <= 1'b0;
			clock_func_reset <= 1'b0;
		end
		else
		begin
			sec_inc <= !hold && (tick_1hz || pend_q);
			clock_func_reset <= cnt_reset;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Open-drain interrupt pin

	assign drive_low = (timer_irq_enable && (pulse_mode ? rtn_cnt_q != '0 : tf_q))
		|| (alarm_irq_enable && af_q)
		|| (fe && !alarm_irq_enable && !timer_irq_enable && !wave_q);

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			irq_out_n <= 1'b0;
			irq_out_n_oe <= 1'b0;
		end
		else
		begin
			irq_out_n <= 1'b0;
			irq_out_n_oe <= drive_low;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_pin_never_high: assert property (@(posedge mclk) disable iff (reset)
		irq_out_n_oe |-> !irq_out_n) else $error("pin driven high");
	a_flag_write_one: assert property (@(posedge mclk) disable iff (reset)
		wr_e && reg_wr.data[TIMER_FLAG_BIT] && tf_q |=> tf_q)
		else $error("timer flag lost on write of one");
	a_alarm_sets_flag: assert property (@(posedge mclk) disable iff (reset)
		sec_carry && alarm_q[0][7] && alarm_q[1][7] && alarm_q[2][7]
		&& alarm_q[3][7] |=> af_q)
		else $error("fully masked alarm did not fire");
	a_preset_load: assert property (@(posedge mclk) disable iff (reset)
		reg_wr.en && reg_wr.addr == ADDR_INTERVAL
		|=> count_q == $past(reg_wr.data) && preset_q == count_q)
		else $error("interval write not loaded");
	a_stopped_holds: assert property (@(posedge mclk) disable iff (reset)
		!timer_sel_q[RUN_BIT] ##1 !timer_sel_q[RUN_BIT]
		|-> count_q == $past(preset_q, 1) || $past(reg_wr.en))
		else $error("stopped counter moved");
	a_reload_event: assert property (@(posedge mclk) disable iff (reset)
		timer_event |=> tf_q && count_q == $past(preset_q))
		else $error("no reload after zero");
	a_level_low: assert property (@(posedge mclk) disable iff (reset)
		timer_irq_enable && !pulse_mode && tf_q && !wr_e |=> irq_out_n_oe)
		else $error("level interrupt released early");
	a_hold_no_step: assert property (@(posedge mclk) disable iff (reset)
		hold && tick_1hz |=> !sec_inc ##1 pend_q || !hold)
		else $error("seconds stepped during hold");
	a_ce_clears_reset: assert property (@(posedge mclk) disable iff (reset)
		ce_fall && !wr_f |=> !cnt_reset ##1 !clock_func_reset)
		else $error("counter reset not cleared");
	a_freq_off: assert property (@(posedge mclk) disable iff (reset)
		!fe && !alarm_irq_enable && !timer_irq_enable |=> !irq_out_n_oe)
		else $error("pin driven with output disabled");

endmodule

// ===== dv/host_model.sv
// Host-side register port model standing in for the serial engine
`timescale 1ns/100ps
module host_model
	import rtc_alarm_pkg::*;
(
	input wire logic mclk,
	input wire logic [7:0] rd_data,
	output reg_wr_t reg_wr,
	output logic [3:0] rd_addr
);
	initial
	begin
		reg_wr = '0;
		rd_addr = 4'h0;
	end
	////////////////////////////////////////////////////////////////////////
	// One-cycle write strobe, raised and dropped between sampling edges
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_wr.addr = a;
		reg_wr.data = (a == ADDR_CLOCK_CTRL) ? (d & 8'hBF) : d;
		reg_wr.en = 1'b1;
		@(negedge mclk);
		reg_wr.en = 1'b0;
		// Idle bus shows the inverse so a stale byte is never reused
		reg_wr.data = ~reg_wr.data;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge mclk);
		rd_addr = a;
		@(negedge mclk);
		@(negedge mclk);
		d = rd_data;
	endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the alarm, timer and frequency-output block
`timescale 1ns/100ps
module tb_top
	import rtc_alarm_pkg::*;
;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic osc_in = 1'b0;
	logic ce_fall = 1'b0;
	logic sec_carry = 1'b0;
	cal_time_t cal = '0;
	reg_wr_t reg_wr;
	logic [3:0] rd_addr;
	logic [7:0] rd_data;
	logic sec_inc, clock_func_reset, pin_o, pin_oe;
	logic [7:0] mdl [16];
	logic [31:0] seed = 32'd89843;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	int inc_cnt = 0;
	// Oscillator run fast so the long divider ratios fit the run
	localparam int OSC_CYC = 152;
	localparam int TICK_CYC = 8 * OSC_CYC;
	always #25 mclk = ~mclk;
	always #3800 osc_in = ~osc_in;
	rtc_alarm_timer #(.RTN_MID_CYCLES(20), .RTN_LONG_CYCLES(40)) uut (
		.mclk(mclk), .reset(reset), .osc_in(osc_in), .reg_wr(reg_wr),
		.rd_addr(rd_addr), .ce_fall(ce_fall), .cal(cal),
		.sec_carry(sec_carry), .rd_data(rd_data), .sec_inc(sec_inc),
		.clock_func_reset(clock_func_reset), .irq_out_n(pin_o),
		.irq_out_n_oe(pin_oe));
	host_model host (.mclk(mclk), .rd_data(rd_data), .reg_wr(reg_wr),
		.rd_addr(rd_addr));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic near(input int seen, input int exp);
		check((seen >= exp - 3 && seen <= exp + 3) ? exp : seen, exp);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		host.wr(a, d);
		// Flags only take zero, other bits are plain storage
		if (a == ADDR_IRQ_CTRL)
			mdl[a] = (d & 8'hF3) | (mdl[a] & d & 8'h0C);
		else
			mdl[a] = (a == ADDR_CLOCK_CTRL) ? (d & 8'hBF) : d;
	endtask
	task automatic rdchk(input logic [3:0] a);
		logic [7:0] v;
		host.rd(a, v);
		check(v, mdl[a]);
	endtask
	// Waits for the pin enable to reach v; reports the time it arrived
	task automatic wait_oe(input logic v, output realtime t);
		int n;
		n = 0;
		while (pin_oe !== v && n < 20000)
		begin
			@(negedge mclk);
			n++;
		end
		check(pin_oe, v);
		t = $realtime;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic pulse_carry();
		@(negedge mclk);
		sec_carry = 1'b1;
		@(negedge mclk);
		sec_carry = 1'b0;
		idle(3);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 100000)
		begin
			error_cnt++;
			print_verdict();
		end
	end
	always @(negedge mclk)
		if (pin_oe === 1'b1)
			check(pin_o, 1'b0);
	// Seconds steps seen; the run is far shorter than one divided second
	always @(negedge mclk)
		if (sec_inc !== 1'b0)
			inc_cnt++;
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		static int ratio [8] = '{1, 2, 3, 6, 5, 10, 15, 30};
		static logic [7:0] wd [5] = '{8'h02, 8'h01, 8'h02, 8'h40, 8'h20};
		static logic [7:0] mn [5] = '{8'h30, 8'h30, 8'h31, 8'h30, 8'h30};
		static logic [4:0] hit = 5'h11;
		realtime t0, t1;
		for (int a = 0; a < 16; a++)
			mdl[a] = REG_RESET;
		idle(12);
		reset = 1'b0;
		for (int a = 0; a < 16; a++)
			rdchk(4'(a));
		for (int a = 7; a < 16; a++)
		begin
			seed = lfsr(seed);
			wr(4'(a), (a == 14) ? (seed[7:0] | 8'h0C) & 8'hFC
				: seed[7:0] & 8'hAF);
			rdchk(4'(a));
		end
		wr(ADDR_FREQ_OUTPUT, 8'h00);
		wr(ADDR_IRQ_CTRL, 8'h00);
		wr(ADDR_CLOCK_CTRL, 8'h10);
		idle(2);
		check(clock_func_reset, 1'b1);
		@(negedge mclk);
		ce_fall = 1'b1;
		@(negedge mclk);
		ce_fall = 1'b0;
		mdl[15] = 8'h00;
		idle(2);
		check(clock_func_reset, 1'b0);
		rdchk(ADDR_CLOCK_CTRL);
		// Hold set for a few cycles only, far under one second
		wr(ADDR_CLOCK_CTRL, 8'h08);
		rdchk(ADDR_CLOCK_CTRL);
		wr(ADDR_CLOCK_CTRL, 8'h00);
		idle(2);
		check(sec_inc, 1'b0);
		// Alarm on minute and Monday-to-Friday, hour and day masked
		wr(ADDR_ALARM_MINUTE, 8'h30);
		wr(ADDR_ALARM_HOUR, 8'h80);
		wr(ADDR_ALARM_WEEKDAY, 8'h3E);
		wr(ADDR_ALARM_DAY, 8'h80);
		wr(ADDR_IRQ_CTRL, 8'h02);
		for (int i = 0; i < 5; i++)
		begin
			cal = '{mn[i], 8'h12, wd[i], 8'h15};
			pulse_carry();
			check(pin_oe, hit[i]);
			if (hit[i])
				mdl[14] = mdl[14] | 8'h08;
			rdchk(ADDR_IRQ_CTRL);
			wr(ADDR_IRQ_CTRL, 8'h02);
			idle(2);
			check(pin_oe, 1'b0);
		end
		wr(ADDR_IRQ_CTRL, 8'h00);
		cal = '{8'h30, 8'h12, 8'h02, 8'h15};
		pulse_carry();
		check(pin_oe, 1'b0);
		mdl[14] = 8'h08;
		rdchk(ADDR_IRQ_CTRL);
		// Timer: preset 3 at 4096 Hz, first held stopped
		wr(ADDR_IRQ_CTRL, 8'h01);
		wr(ADDR_INTERVAL, 8'h03);
		wr(ADDR_TIMER_SOURCE, 8'h00);
		idle(5000);
		check(pin_oe, 1'b0);
		wr(ADDR_TIMER_SOURCE, 8'h80);
		wait_oe(1'b1, t0);
		idle(200);
		check(pin_oe, 1'b1);
		wr(ADDR_IRQ_CTRL, 8'h01);
		idle(2);
		check(pin_oe, 1'b0);
		wait_oe(1'b1, t1);
		near(int'((t1 - t0) / 50), 3 * TICK_CYC);
		wr(ADDR_IRQ_CTRL, 8'h11);
		wait_oe(1'b0, t0);
		wait_oe(1'b1, t0);
		wait_oe(1'b0, t1);
		near(int'((t1 - t0) / 50), RTN_SHORT_CYC);
		mdl[14] = 8'h15;
		rdchk(ADDR_IRQ_CTRL);
		wr(ADDR_TIMER_SOURCE, 8'h00);
		// Frequency output over every divider code
		wr(ADDR_IRQ_CTRL, 8'h00);
		for (int s = 0; s < 9; s++)
		begin
			wr(ADDR_FREQ_OUTPUT, (s == 8) ? 8'h88 : 8'h80 | 8'(s));
			wait_oe(1'b0, t0);
			wait_oe(1'b1, t0);
			wait_oe(1'b0, t1);
			wait_oe(1'b1, t1);
			near(int'((t1 - t0) / 50), (s == 8) ? 32 * OSC_CYC :
				ratio[s] * OSC_CYC);
		end
		wr(ADDR_FREQ_OUTPUT, 8'h00);
		idle(400);
		check(pin_oe, 1'b0);
		check(inc_cnt, 0);
		print_verdict();
	end
endmodule
